// *** pkg/asp_pkg.sv ***
// package for the async serial port baud divider and register block
// Contract
// - receiver samples the input line at a rate divided down by the divisor
// - transmitter drives output at bit start, timed independently of reception
// - high divisor bits 4:0 are buffered, bits 7:5 act at once; working divisor updates only on low byte write
// - divisor of zero stops the baud generator entirely
// - divisor 1..8191 gives baud equal to bus clock over sixteen times divisor
// - low divisor resets nonzero, generator idle until rx_on or tx_on written one
// - high divisor bit 7 lets line_break_flag request an interrupt
// - high divisor bit 6 lets rx_edge_flag request an interrupt
// - high divisor bit 5 selects one or two stop bits
package asp_pkg;
	// registers at printed offsets are not word multiples: these are indices, byte address is four times
	localparam logic [15:0] IDX_BAUD_DIVISOR_HIGH = 16'h3080;
	localparam logic [15:0] IDX_BAUD_DIVISOR_LOW = 16'h3081;
	localparam logic [15:0] IDX_CONTROL_FIRST = 16'h3082;
	localparam logic [15:0] IDX_CONTROL_SECOND = 16'h3083;
	localparam logic [15:0] IDX_STATUS_FIRST = 16'h3084;
	localparam logic [15:0] IDX_STATUS_SECOND = 16'h3085;
	localparam logic [15:0] IDX_CONTROL_THIRD = 16'h3086;
	localparam logic [15:0] IDX_DATA_PORT = 16'h3087;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h3088;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h3089;
	localparam int ADDR_W = 18;
	localparam logic [7:0] RST_BAUD_DIVISOR_HIGH = 8'h00;
	localparam logic [7:0] RST_BAUD_DIVISOR_LOW = 8'h04;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_STATUS_FIRST = 8'hc0;
	localparam logic [7:0] RST_DATA_PORT = 8'h00;
	localparam int BIT_LINE_BREAK_IRQ_ENABLE = 7;
	localparam int BIT_RX_EDGE_IRQ_ENABLE = 6;
	localparam int BIT_STOP_BIT_COUNT_SELECT = 5;
	localparam int BIT_TX_ON = 3;
	localparam int BIT_RX_ON = 2;
	localparam int BIT_LINE_BREAK_FLAG = 7;
	localparam int BIT_RX_EDGE_FLAG = 6;
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_TX_DONE = 6;
	localparam int DIV_W = 13;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// irq status bits
	localparam int EV_LINE_BREAK = 0;
	localparam int EV_RX_EDGE = 1;
	localparam int EV_TX_DONE = 2;
	localparam int EV_RX_FULL = 3;
	localparam int EV_N = 4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} asp_wreq_t;
endpackage

// *** rtl/asp_top.sv ***
// async serial port: baud divider, register file, minimal tx/rx, AXI4-Lite slave
`timescale 1ns/10ps
module asp_top
	import asp_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [asp_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [asp_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic RXD,
	output logic TXD_O,
	output logic TXD_OE,
	output logic IRQ
);
	// =========================================
	// register bus slave
	logic aw_held, w_held;
	asp_wreq_t wreq;
	logic [7:0] div_high, div_low, div_high_buf, ctl1, ctl2, ctl3, data_tx, data_rx;
	logic [EV_N-1:0] irq_status, irq_mask;
	logic gen_armed, line_break_flag, rx_edge_flag;
	logic tx_empty, tx_done, rx_full;

	function automatic logic [15:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[ADDR_W-1:2];
	endfunction

	wire wr_fire = aw_held && w_held && !BVALID;
	// an unaligned write answers with an error and must not land in the register it aliases
	wire wr_lane0 = wreq.strb[0] && wreq.addr[1:0] == 2'b00;
	wire [15:0] widx = idx_of(wreq.addr);
	wire [7:0] wbyte = wreq.data[7:0];
	wire wr_ok = (widx >= IDX_BAUD_DIVISOR_HIGH) && (widx <= IDX_IRQ_MASK) && (wreq.addr[1:0] == 2'b00);
	wire wr_bdh = wr_fire && wr_lane0 && widx == IDX_BAUD_DIVISOR_HIGH;
	wire wr_bdl = wr_fire && wr_lane0 && widx == IDX_BAUD_DIVISOR_LOW;
	wire wr_c1 = wr_fire && wr_lane0 && widx == IDX_CONTROL_FIRST;
	wire wr_c2 = wr_fire && wr_lane0 && widx == IDX_CONTROL_SECOND;
	wire wr_s2 = wr_fire && wr_lane0 && widx == IDX_STATUS_SECOND;
	wire wr_c3 = wr_fire && wr_lane0 && widx == IDX_CONTROL_THIRD;
	wire wr_d = wr_fire && wr_lane0 && widx == IDX_DATA_PORT;
	wire wr_ist = wr_fire && wr_lane0 && widx == IDX_IRQ_STATUS;
	wire wr_imk = wr_fire && wr_lane0 && widx == IDX_IRQ_MASK;
	wire [15:0] ridx = idx_of(ARADDR);
	wire rd_fire = ARVALID && !RVALID;
	wire rd_data = rd_fire && ARADDR[1:0] == 2'b00 && ridx == IDX_DATA_PORT;

	assign AWREADY = !aw_held;
	assign WREADY = !w_held;
	assign ARREADY = !RVALID;

	wire [7:0] status_first = {tx_empty, tx_done, rx_full, 5'h00};
	wire [7:0] status_second = {line_break_flag, rx_edge_flag, 6'h00};
	logic [7:0] rbyte;
	logic rd_ok;
	always_comb
	begin
		rd_ok = ARADDR[1:0] == 2'b00;
		unique case (ridx)
			IDX_BAUD_DIVISOR_HIGH: rbyte = div_high;
			IDX_BAUD_DIVISOR_LOW: rbyte = div_low;
			IDX_CONTROL_FIRST: rbyte = ctl1;
			IDX_CONTROL_SECOND: rbyte = ctl2;
			IDX_STATUS_FIRST: rbyte = status_first;
			IDX_STATUS_SECOND: rbyte = status_second;
			IDX_CONTROL_THIRD: rbyte = ctl3;
			IDX_DATA_PORT: rbyte = data_rx;
			IDX_IRQ_STATUS: rbyte = {4'h0, irq_status};
			IDX_IRQ_MASK: rbyte = {4'h0, irq_mask};
			default:
			begin
				rbyte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wreq <= '0;
			BVALID <= 1'b0;
			BRESP <= RESP_OKAY;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= RESP_OKAY;
		end
		else if (CE)
		begin
			if (AWVALID && AWREADY)
			begin
				aw_held <= 1'b1;
				wreq.addr <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				w_held <= 1'b1;
				wreq.data <= WDATA;
				wreq.strb <= WSTRB;
			end
			if (wr_fire)
			begin
				BVALID <= 1'b1;
				BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (BVALID && BREADY)
			begin
				BVALID <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
			if (rd_fire)
			begin
				RVALID <= 1'b1;
				RDATA <= {24'h000000, rbyte};
				RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (RVALID && RREADY)
				RVALID <= 1'b0;
		end
	end

	// =========================================
	// control registers
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			div_high <= RST_BAUD_DIVISOR_HIGH;
			div_high_buf <= RST_BAUD_DIVISOR_HIGH;
			div_low <= RST_BAUD_DIVISOR_LOW;
			ctl1 <= RST_CONTROL;
			ctl2 <= RST_CONTROL;
			ctl3 <= RST_CONTROL;
			irq_mask <= '0;
			gen_armed <= 1'b0;
		end
		else if (CE)
		begin
			if (wr_bdh)
			begin
				div_high_buf <= wbyte;
				// enables and stop select act at once; only the divisor part waits
				div_high[7:5] <= wbyte[7:5];
			end
			if (wr_bdl)
			begin
				div_low <= wbyte;
				div_high[4:0] <= div_high_buf[4:0];
			end
			if (wr_c1)
				ctl1 <= wbyte;
			if (wr_c2)
				ctl2 <= wbyte;
			if (wr_c3)
				ctl3 <= wbyte;
			if (wr_imk)
				irq_mask <= wbyte[EV_N-1:0];
			if (wr_c2 && (wbyte[BIT_RX_ON] || wbyte[BIT_TX_ON]))
				gen_armed <= 1'b1;
		end
	end

	// =========================================
	// baud generator: sixteen ticks per bit
	wire [DIV_W-1:0] baud_divisor_value = {div_high[4:0], div_low};
	wire gen_run = gen_armed && baud_divisor_value != '0;
	logic [DIV_W-1:0] div_cnt;
	wire tick16 = gen_run && div_cnt == DIV_W'(1);
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			div_cnt <= '0;
		else if (CE)
		begin
			if (!gen_run)
				div_cnt <= '0;
			else if (div_cnt <= DIV_W'(1))
				div_cnt <= baud_divisor_value;
			else
				div_cnt <= div_cnt - DIV_W'(1);
		end
	end

	// =========================================
	// pin sync and receiver
	logic rx_s1, rx_s2, rx_prev;
	logic [3:0] rx_phase, tx_phase;
	logic [3:0] rx_bit, tx_bit;
	logic rx_busy, tx_busy;
	logic [7:0] rx_shift;
	logic [10:0] low_run;
	wire rx_on = ctl2[BIT_RX_ON];
	wire tx_on = ctl2[BIT_TX_ON];
	wire rx_fall = rx_on && rx_prev && !rx_s2;
	wire rx_mid = tick16 && rx_busy && rx_phase == 4'h7;
	wire rx_stop = rx_mid && rx_bit == 4'h9;
	wire brk_seen = rx_stop && !rx_s2 && rx_shift == 8'h00;
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_prev <= 1'b1;
			rx_busy <= 1'b0;
			rx_phase <= 4'h0;
			rx_bit <= 4'h0;
			rx_shift <= 8'h00;
			data_rx <= RST_DATA_PORT;
			rx_full <= 1'b0;
		end
		else if (CE)
		begin
			rx_s1 <= RXD;
			rx_s2 <= rx_s1;
			rx_prev <= rx_s2;
			if (!rx_busy && rx_fall && gen_run)
			begin
				rx_busy <= 1'b1;
				rx_phase <= 4'h0;
				rx_bit <= 4'h0;
			end
			else if (rx_busy && tick16)
			begin
				rx_phase <= rx_phase + 4'h1;
				if (rx_mid)
				begin
					rx_bit <= rx_bit + 4'h1;
					if (rx_bit == 4'h0 && rx_s2)
						rx_busy <= 1'b0;
					else if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
						rx_shift <= {rx_s2, rx_shift[7:1]};
					else if (rx_stop)
					begin
						rx_busy <= 1'b0;
						data_rx <= rx_shift;
					end
				end
			end
			if (rx_stop && rx_s2)
				rx_full <= 1'b1;
			else if (rd_data)
				rx_full <= 1'b0;
		end
	end

	// =========================================
	// transmitter runs from its own phase counter, never from the receiver
	wire stop_two = div_high[BIT_STOP_BIT_COUNT_SELECT];
	wire [3:0] tx_last = stop_two ? 4'ha : 4'h9;
	wire tx_bit_end = tick16 && tx_busy && tx_phase == OVERSAMPLE_LAST;
	logic [8:0] tx_shift;
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_busy <= 1'b0;
			tx_phase <= 4'h0;
			tx_bit <= 4'h0;
			tx_shift <= 9'h1ff;
			TXD_O <= 1'b1;
			data_tx <= RST_DATA_PORT;
			tx_empty <= 1'b1;
			tx_done <= 1'b1;
		end
		else if (CE)
		begin
			if (wr_d)
			begin
				data_tx <= wbyte;
				tx_empty <= 1'b0;
			end
			if (!tx_busy && !tx_empty && tx_on && gen_run)
			begin
				tx_busy <= 1'b1;
				tx_phase <= 4'h0;
				tx_bit <= 4'h0;
				tx_shift <= {data_tx, 1'b0};
				TXD_O <= 1'b0;
				// a byte written in the very cycle the pending one starts stays pending
				tx_empty <= !wr_d;
				tx_done <= 1'b0;
			end
			else if (tx_busy && tick16)
			begin
				tx_phase <= tx_phase + 4'h1;
				if (tx_bit_end)
				begin
					tx_bit <= tx_bit + 4'h1;
					tx_shift <= {1'b1, tx_shift[8:1]};
					TXD_O <= tx_shift[1];
					if (tx_bit == tx_last)
					begin
						tx_busy <= 1'b0;
						tx_done <= 1'b1;
						TXD_O <= 1'b1;
					end
				end
			end
		end
	end
	assign TXD_OE = tx_on;

	// =========================================
	// flags and interrupt
	wire [EV_N-1:0] events = {rx_stop && rx_s2, tx_bit_end && tx_bit == tx_last, rx_fall, brk_seen};
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			line_break_flag <= 1'b0;
			rx_edge_flag <= 1'b0;
			irq_status <= '0;
		end
		else if (CE)
		begin
			// set beats a write-one clear in the same cycle
			irq_status <= (irq_status & ~(wr_ist ? wbyte[EV_N-1:0] : '0)) | events;
			line_break_flag <= (line_break_flag && !(wr_s2 && wbyte[BIT_LINE_BREAK_FLAG])) || brk_seen;
			rx_edge_flag <= (rx_edge_flag && !(wr_s2 && wbyte[BIT_RX_EDGE_FLAG])) || rx_fall;
		end
	end
	wire brk_irq = div_high[BIT_LINE_BREAK_IRQ_ENABLE] && line_break_flag;
	wire edge_irq = div_high[BIT_RX_EDGE_IRQ_ENABLE] && rx_edge_flag;
	assign IRQ = brk_irq || edge_irq || |(irq_status & irq_mask);
endmodule

// *** testbench/asp_peer.sv ***
// behavioural far-end transceiver on the serial line
`timescale 1ns/10ps
module asp_peer #(
	parameter int BIT_LEN = 32
) (
	input wire logic clk,
	input wire logic txd,
	input wire logic txd_oe,
	output logic rxd
);
	logic [7:0] got_byte;
	time t_start;
	initial
	begin
		rxd = 1'b1;
		got_byte = 8'h00;
		t_start = 0;
	end
	// sample each bit at its centre, lsb first
	always
	begin
		@(negedge txd iff txd_oe === 1'b1);
		t_start = $time;
		repeat (BIT_LEN / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_LEN) @(posedge clk);
			got_byte[i] = txd;
		end
	end
	// start bit, eight data bits, one stop bit; a zero byte with a low stop makes a break
	task send(input logic [7:0] v, input logic stop);
		@(posedge clk);
		rxd <= 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			repeat (BIT_LEN) @(posedge clk);
			rxd <= (i < 8) ? v[i] : stop;
		end
		repeat (BIT_LEN) @(posedge clk);
		rxd <= 1'b1;
	endtask
endmodule

// *** testbench/asp_top_asserts.sv ***
// concurrent checks on the bus and line ports of the serial port
`timescale 1ns/10ps
module asp_top_asserts (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic TXD_O,
	input wire logic TXD_OE
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// ==========
	// write channel
	sequence s_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	a_write_answer: assert property (s_taken |-> ##[1:3] BVALID)
		else $error("write response missing");
	a_write_refused: assert property (s_taken |=> !AWREADY && !WREADY)
		else $error("write accepted while busy");
	a_bvalid_stands: assert property (BVALID && !BREADY |=> BVALID)
		else $error("write response dropped early");
	a_bvalid_drops: assert property (BVALID && BREADY |=> !BVALID)
		else $error("write response repeated");
	// ==========
	// read channel and line
	a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read data late");
	a_rdata_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data changed before taken");
	a_rdata_byte: assert property (RVALID |-> RDATA[31:8] == 24'h0)
		else $error("read data above byte lane");
	a_line_idle: assert property (!TXD_OE |-> TXD_O)
		else $error("line not idle while disabled");
endmodule
bind asp_top asp_top_asserts u_chk (
	.CLK(CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
	.RREADY(RREADY), .TXD_O(TXD_O), .TXD_OE(TXD_OE)
);

// *** testbench/asp_top_tb.sv ***
// self-checking bench for the async serial port
`timescale 1ns/10ps
module asp_top_tb;
	import asp_pkg::*;
	localparam int BITC = 32;
	localparam logic [7:0] RST_V [8] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00};
	logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, RXD, TXD_O, TXD_OE, IRQ;
	logic [ADDR_W-1:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [1:0] BRESP, RRESP, r;
	logic [7:0] d;
	int mismatches, tests_run, n;
	asp_top dut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'h1), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.RXD(RXD), .TXD_O(TXD_O), .TXD_OE(TXD_OE), .IRQ(IRQ));
	asp_peer #(.BIT_LEN(BITC)) peer (.clk(CLK), .txd(TXD_O), .txd_oe(TXD_OE), .rxd(RXD));
	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	// ==========
	// reporting
	task bad(input string s);
		mismatches++;
		$display("mismatch at %0t: %0s", $time, s);
	endtask
	task chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e)
			bad($sformatf("got %0h expected %0h", g, e));
	endtask
	task chkr(input int g, lo, hi);
		tests_run++;
		if (g < lo || g > hi)
			bad($sformatf("count %0d outside %0d..%0d", g, lo, hi));
	endtask
	task endt(input string s);
		$display("test %0s finished", s);
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========
	// bus master: byte address is four times the register index
	task wr(input logic [15:0] i, input logic [7:0] v);
		bit aw, w;
		aw = 0;
		w = 0;
		AWADDR <= {i, 2'b00};
		WDATA <= {24'h0, v};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge CLK);
			aw = aw || AWREADY === 1'b1;
			w = w || WREADY === 1'b1;
			AWVALID <= !aw;
			WVALID <= !w;
		end
		// late ready exercises the response standing
		do @(posedge CLK); while (BVALID !== 1'b1);
		BREADY <= 1'b1;
		do @(posedge CLK); while (BVALID !== 1'b1);
		r = BRESP;
		BREADY <= 1'b0;
	endtask
	task rd(input logic [15:0] i);
		ARADDR <= {i, 2'b00};
		ARVALID <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		@(posedge CLK);
		RREADY <= 1'b1;
		do @(posedge CLK); while (RVALID !== 1'b1);
		d = RDATA[7:0];
		r = RRESP;
		RREADY <= 1'b0;
	endtask
	task rchk(input logic [15:0] i, input logic [7:0] e, m);
		rd(i);
		chk(d & m, e);
	endtask
	task txf(input logic [7:0] v, input int bits);
		wr(IDX_DATA_PORT, v);
		while (IRQ !== 1'b1) @(posedge CLK);
		n = int'(($time - peer.t_start) / 5);
		chkr(n, bits * BITC - 8, bits * BITC + 16);
		chk(peer.got_byte, v);
		wr(IDX_IRQ_STATUS, 8'h04);
		chk(IRQ, 1'b0);
	endtask
	// ==========
	// tests
	initial
	begin
		RST_N = 1'b0;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		AWADDR = '0;
		ARADDR = '0;
		WDATA = 32'h0;
		mismatches = 0;
		tests_run = 0;
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		chk(TXD_OE, 1'b0);
		chk(IRQ, 1'b0);
		for (int i = 0; i < 8; i++)
			rchk(IDX_BAUD_DIVISOR_HIGH + 16'(i), RST_V[i], 8'hff);
		rd(16'h3090);
		chk(r, RESP_SLVERR);
		chk(d, 8'h00);
		wr(16'h3090, 8'h55);
		chk(r, RESP_SLVERR);
		endt("reset");
		wr(IDX_BAUD_DIVISOR_HIGH, 8'h01);
		chk(r, RESP_OKAY);
		rchk(IDX_BAUD_DIVISOR_HIGH, 8'h00, 8'h1f);
		wr(IDX_BAUD_DIVISOR_LOW, 8'h02);
		rchk(IDX_BAUD_DIVISOR_HIGH, 8'h01, 8'h1f);
		rchk(IDX_BAUD_DIVISOR_LOW, 8'h02, 8'hff);
		wr(IDX_BAUD_DIVISOR_HIGH, 8'h00);
		wr(IDX_BAUD_DIVISOR_LOW, 8'h02);
		endt("divisor");
		wr(IDX_CONTROL_SECOND, 8'h0c);
		wr(IDX_IRQ_STATUS, 8'h0f);
		wr(IDX_IRQ_MASK, 8'h04);
		chk(TXD_OE, 1'b1);
		txf(8'ha5, 10);
		wr(IDX_BAUD_DIVISOR_HIGH, 8'h20);
		txf(8'h3c, 11);
		wr(IDX_BAUD_DIVISOR_HIGH, 8'h00);
		endt("transmit");
		peer.send(8'h5a, 1'b1);
		rchk(IDX_STATUS_FIRST, 8'he0, 8'he0);
		rchk(IDX_DATA_PORT, 8'h5a, 8'hff);
		rchk(IDX_STATUS_FIRST, 8'h00, 8'h20);
		rchk(IDX_STATUS_SECOND, 8'h40, 8'hc0);
		chk(IRQ, 1'b0);
		wr(IDX_BAUD_DIVISOR_HIGH, 8'h40);
		chk(IRQ, 1'b1);
		wr(IDX_STATUS_SECOND, 8'h40);
		chk(IRQ, 1'b0);
		endt("receive");
		wr(IDX_BAUD_DIVISOR_HIGH, 8'h80);
		peer.send(8'h00, 1'b0);
		rchk(IDX_STATUS_SECOND, 8'h80, 8'h80);
		chk(IRQ, 1'b1);
		wr(IDX_STATUS_SECOND, 8'hc0);
		chk(IRQ, 1'b0);
		endt("break");
		wr(IDX_BAUD_DIVISOR_LOW, 8'h00);
		wr(IDX_DATA_PORT, 8'h11);
		repeat (400) @(posedge CLK);
		chk(TXD_O, 1'b1);
		rchk(IDX_STATUS_FIRST, 8'h40, 8'hc0);
		endt("stopped");
		summarize;
	end
	// the tests need a few thousand cycles; this is ample
	initial
	begin
		repeat (20000) @(posedge CLK);
		bad("watchdog expired");
		summarize;
	end
endmodule
